// *** rtl/asfr_pkg.sv ***
package asfr_pkg;

	// Data path and flag register geometry.
	localparam int DATA_W     = 8;
	localparam int FLAG_COUNT = 5;

	// Flag positions inside the flag register.
	localparam int BIT_C           = 0;
	localparam int BIT_NIBBLE_WRAP = 1;
	localparam int BIT_Z           = 2;
	localparam int BIT_SIGNED_WRAP = 3;
	localparam int BIT_N           = 4;

	// Implemented bits; bits 7 to 5 always read as zero.
	localparam logic [7:0] FLAGS_IMPL_MASK = 8'h1f;
	localparam logic [4:0] FLAGS_RESET     = 5'h00;

	// Which flags each class of instruction updates, ordered negative, signed wrap,
	// zero, nibble wrap, carry.
	localparam logic [4:0] AFF_ARITH = 5'h1f;
	localparam logic [4:0] AFF_LOGIC = 5'h14;
	localparam logic [4:0] AFF_ZERO  = 5'h04;
	localparam logic [4:0] AFF_ROT   = 5'h17;
	localparam logic [4:0] AFF_NONE  = 5'h00;

	// Single-bit masks and the carry-in of a two's complement subtraction.
	localparam logic [7:0] BIT_ONE  = 8'h01;
	localparam logic [8:0] SUB_CIN9 = 9'h001;
	localparam logic [4:0] SUB_CIN5 = 5'h01;

	typedef enum logic [3:0] {
		OP_ADD                          = 4'h0,
		OP_SUB                          = 4'h1,
		OP_AND                          = 4'h2,
		OP_IOR                          = 4'h3,
		OP_XOR                          = 4'h4,
		OP_FILE_WIPE                    = 4'h5,
		OP_ROTATE_LEFT                  = 4'h6,
		OP_ROTATE_RIGHT                 = 4'h7,
		OP_BIT_CLEAR                    = 4'h8,
		OP_BIT_SET                      = 4'h9,
		OP_NIBBLE_EXCHANGE              = 4'ha,
		OP_FILE_TO_FILE_MOVE            = 4'hb,
		OP_ACCUMULATOR_TO_FILE_MOVE     = 4'hc,
		OP_INC                          = 4'hd,
		OP_DEC                          = 4'he
	} asfr_op_t;

endpackage : asfr_pkg

// *** rtl/asfr_alu.sv ***
`timescale 1ns/1ps
`default_nettype none

module asfr_alu (
	input  wire asfr_pkg::asfr_op_t op,
	input  wire logic [7:0]         opa,
	input  wire logic [7:0]         opb,
	input  wire logic               cin,
	input  wire logic [2:0]         bit_sel,
	output logic      [7:0]         res,
	output logic      [4:0]         flags,
	output logic      [4:0]         affect
);

	// Signed overflow of a sum: equal operand signs, different result sign.
	function automatic logic signed_ovf(input logic [7:0] a, input logic [7:0] b,
					    input logic [7:0] r);
		signed_ovf = (a[7] == b[7]) && (r[7] != a[7]);
	endfunction : signed_ovf

	// Sum of two bytes with carry-in, returning carry out of bit 7 on top.
	function automatic logic [8:0] add9(input logic [7:0] a, input logic [7:0] b,
					    input logic ci);
		add9 = {1'b0, a} + {1'b0, b} + {8'h00, ci};
	endfunction : add9

	// Sum of two nibbles with carry-in, carry out of bit 3 on top.
	function automatic logic [4:0] add5(input logic [3:0] a, input logic [3:0] b,
					    input logic ci);
		add5 = {1'b0, a} + {1'b0, b} + {4'h0, ci};
	endfunction : add5

	logic [8:0] sum9;
	logic [4:0] sum5;
	logic [7:0] addend;
	logic       c;
	logic       nwrap;
	logic       swrap;

	always_comb begin
		sum9   = '0;
		sum5   = '0;
		addend = 8'h00;
		res    = opa;
		c      = 1'b0;
		nwrap  = 1'b0;
		swrap  = 1'b0;
		affect = asfr_pkg::AFF_NONE;
		case (op)
			asfr_pkg::OP_ADD, asfr_pkg::OP_SUB, asfr_pkg::OP_INC, asfr_pkg::OP_DEC: begin
				// Subtraction adds the two's complement, so the carry and the
				// nibble wrap come out as inverted borrows with no extra inversion.
				case (op)
					asfr_pkg::OP_ADD: addend = opb;
					asfr_pkg::OP_SUB: addend = ~opb;
					asfr_pkg::OP_INC: addend = 8'h01;
					default:          addend = 8'hff;
				endcase
				sum9   = add9(opa, addend, op == asfr_pkg::OP_SUB);
				sum5   = add5(opa[3:0], addend[3:0], op == asfr_pkg::OP_SUB);
				res    = sum9[7:0];
				c      = sum9[8];
				nwrap  = sum5[4];
				swrap  = signed_ovf(opa, addend, sum9[7:0]);
				affect = asfr_pkg::AFF_ARITH;
			end
			asfr_pkg::OP_AND: begin
				res    = opa & opb;
				affect = asfr_pkg::AFF_LOGIC;
			end
			asfr_pkg::OP_IOR: begin
				res    = opa | opb;
				affect = asfr_pkg::AFF_LOGIC;
			end
			asfr_pkg::OP_XOR: begin
				res    = opa ^ opb;
				affect = asfr_pkg::AFF_LOGIC;
			end
			asfr_pkg::OP_FILE_WIPE: begin
				res    = 8'h00;
				affect = asfr_pkg::AFF_ZERO;
			end
			asfr_pkg::OP_ROTATE_LEFT: begin
				res    = {opa[6:0], cin};
				c      = opa[7];
				nwrap  = opa[3];
				affect = asfr_pkg::AFF_ROT;
			end
			asfr_pkg::OP_ROTATE_RIGHT: begin
				res    = {cin, opa[7:1]};
				c      = opa[0];
				nwrap  = opa[4];
				affect = asfr_pkg::AFF_ROT;
			end
			asfr_pkg::OP_BIT_CLEAR:                   res = opa & ~(asfr_pkg::BIT_ONE << bit_sel);
			asfr_pkg::OP_BIT_SET:                     res = opa | (asfr_pkg::BIT_ONE << bit_sel);
			asfr_pkg::OP_NIBBLE_EXCHANGE:             res = {opa[3:0], opa[7:4]};
			asfr_pkg::OP_FILE_TO_FILE_MOVE:           res = opa;
			asfr_pkg::OP_ACCUMULATOR_TO_FILE_MOVE:    res = opb;
			default:                                  res = opa;
		endcase
	end

	assign flags = {res[7], swrap, res == 8'h00, nwrap, c};

endmodule : asfr_alu

`default_nettype wire

// *** rtl/asfr_flag_reg.sv ***
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Flag-affecting write to flags: logic wins.
// - Bits 7-5 zero; wipe sets zero only.
// - Bit, swap and move ops keep flags unless flags are the destination.
// - Subtract gives inverted borrow and digit borrow.
// - Negative flag mirrors result bit 7.
// - Overflow flag marks signed sign-bit wrap.
// - Flag register usable as source or destination.
// - Zero flag set when result is zero.
// - Digit carry from nibble; rotates load bit.
// - Carry flag holds carry out of bit 7.
// - Rotates load carry with shifted-out bit.
module asfr_flag_reg (
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic               exec_valid,
	input  wire asfr_pkg::asfr_op_t op,
	input  wire logic [7:0]         src_data,
	input  wire logic               src_is_flags,
	input  wire logic [7:0]         acc_data,
	input  wire logic [2:0]         bit_sel,
	input  wire logic               dest_is_flags,
	output logic      [7:0]         flags,
	output logic      [7:0]         result,
	output logic                    result_valid
);

	logic [4:0] flag_q;
	logic [4:0] next_flag_q;
	logic [7:0] next_result;
	logic       next_result_valid;
	logic [7:0] src_operand;
	logic [7:0] alu_res;
	logic [4:0] alu_flags;
	logic [4:0] alu_affect;

	// The upper three bits are not stored at all.
	assign flags = {3'b000, flag_q};

	assign src_operand = src_is_flags ? flags : src_data;

	asfr_alu u_alu (
		.op      (op),
		.opa     (src_operand),
		.opb     (acc_data),
		.cin     (flag_q[asfr_pkg::BIT_C]),
		.bit_sel (bit_sel),
		.res     (alu_res),
		.flags   (alu_flags),
		.affect  (alu_affect)
	);

	always_comb begin
		next_flag_q       = flag_q;
		next_result       = result;
		next_result_valid = 1'b0;
		if (exec_valid) begin
			next_result       = alu_res;
			next_result_valid = 1'b1;
			if (dest_is_flags && (alu_affect == asfr_pkg::AFF_NONE)) begin
				// Plain write of the result into the register.
				next_flag_q = alu_res[4:0];
			end else begin
				// Any flag-affecting instruction blocks the write to all five
				// flags; the ones it does not affect keep their value.
				next_flag_q = (flag_q & ~alu_affect) | (alu_flags & alu_affect);
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flag_q       <= asfr_pkg::FLAGS_RESET;
			result       <= 8'h00;
			result_valid <= 1'b0;
		end else begin
			flag_q       <= next_flag_q;
			result       <= next_result;
			result_valid <= next_result_valid;
		end
	end

	// Reference arithmetic, read only by the checks below.
	logic [8:0] chk_add;
	logic [8:0] chk_sub;
	logic [4:0] chk_nadd;
	logic [4:0] chk_nsub;
	logic       chk_arith;
	logic       chk_nz_op;
	logic       chk_keep_op;

	assign chk_add  = {1'b0, src_operand} + {1'b0, acc_data};
	assign chk_sub  = {1'b0, src_operand} - {1'b0, acc_data};
	assign chk_nadd = {1'b0, src_operand[3:0]} + {1'b0, acc_data[3:0]};
	assign chk_nsub = {1'b0, src_operand[3:0]} - {1'b0, acc_data[3:0]};
	assign chk_arith = (op == asfr_pkg::OP_ADD) || (op == asfr_pkg::OP_SUB);
	assign chk_nz_op = chk_arith || (op == asfr_pkg::OP_AND) || (op == asfr_pkg::OP_IOR) ||
			   (op == asfr_pkg::OP_XOR);
	assign chk_keep_op = (op == asfr_pkg::OP_BIT_CLEAR) || (op == asfr_pkg::OP_BIT_SET) ||
			     (op == asfr_pkg::OP_NIBBLE_EXCHANGE) ||
			     (op == asfr_pkg::OP_FILE_TO_FILE_MOVE) ||
			     (op == asfr_pkg::OP_ACCUMULATOR_TO_FILE_MOVE);

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_dest_arith;
		exec_valid && dest_is_flags && (op == asfr_pkg::OP_ADD) |=>
			flags[asfr_pkg::BIT_C] == $past(chk_add[8]) &&
			flags[asfr_pkg::BIT_Z] == (result == 8'h00);
	endproperty
	a_dest_arith: assert property (p_dest_arith) else $error("flag write not overridden");

	property p_wipe;
		exec_valid && dest_is_flags && (op == asfr_pkg::OP_FILE_WIPE) |=>
			flags == {3'b000, $past(flags[4:3]), 1'b1, $past(flags[1:0])};
	endproperty
	a_wipe: assert property (p_wipe) else $error("wipe of flag register wrong");

	property p_keep;
		exec_valid && !dest_is_flags && chk_keep_op |=> $stable(flags) && result_valid;
	endproperty
	a_keep: assert property (p_keep) else $error("non-flag op changed flags");

	property p_borrow;
		exec_valid && !dest_is_flags && (op == asfr_pkg::OP_SUB) |=>
			flags[asfr_pkg::BIT_C] == !$past(chk_sub[8]) &&
			flags[asfr_pkg::BIT_NIBBLE_WRAP] == !$past(chk_nsub[4]);
	endproperty
	a_borrow: assert property (p_borrow) else $error("borrow polarity wrong");

	property p_neg;
		exec_valid && !dest_is_flags && chk_nz_op |=> flags[asfr_pkg::BIT_N] == result[7];
	endproperty
	a_neg: assert property (p_neg) else $error("negative flag wrong");

	property p_ovf;
		exec_valid && !dest_is_flags && (op == asfr_pkg::OP_ADD) |=>
			flags[asfr_pkg::BIT_SIGNED_WRAP] == $past((src_operand[7] == acc_data[7]) &&
							 (chk_add[7] != src_operand[7]));
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow flag wrong");

	property p_move_in;
		exec_valid && dest_is_flags && (op == asfr_pkg::OP_FILE_TO_FILE_MOVE) |=>
			flags == ($past(src_data) & asfr_pkg::FLAGS_IMPL_MASK) || $past(src_is_flags);
	endproperty
	a_move_in: assert property (p_move_in) else $error("move into flags lost");

	property p_zero;
		exec_valid && !dest_is_flags && chk_nz_op |=>
			flags[asfr_pkg::BIT_Z] == (result == 8'h00) && result_valid;
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");

	property p_dc_add;
		exec_valid && !dest_is_flags && (op == asfr_pkg::OP_ADD) |=>
			flags[asfr_pkg::BIT_NIBBLE_WRAP] == $past(chk_nadd[4]);
	endproperty
	a_dc_add: assert property (p_dc_add) else $error("digit carry wrong");

	property p_carry;
		exec_valid && !dest_is_flags && (op == asfr_pkg::OP_ADD) |=>
			flags[asfr_pkg::BIT_C] == $past(chk_add[8]) && result == $past(chk_add[7:0]);
	endproperty
	a_carry: assert property (p_carry) else $error("carry flag wrong");

	property p_rotate;
		exec_valid && !dest_is_flags && (op == asfr_pkg::OP_ROTATE_LEFT) |=>
			flags[asfr_pkg::BIT_C] == $past(src_operand[7]) &&
			result[0] == $past(flags[asfr_pkg::BIT_C]) &&
			flags[asfr_pkg::BIT_NIBBLE_WRAP] == $past(src_operand[3]);
	endproperty
	a_rotate: assert property (p_rotate) else $error("rotate carry wrong");

	property p_rotate_right;
		exec_valid && !dest_is_flags && (op == asfr_pkg::OP_ROTATE_RIGHT) |=>
			flags[asfr_pkg::BIT_C] == $past(src_operand[0]) &&
			result[7] == $past(flags[asfr_pkg::BIT_C]) &&
			flags[asfr_pkg::BIT_NIBBLE_WRAP] == $past(src_operand[4]);
	endproperty
	a_rotate_right: assert property (p_rotate_right) else $error("rotate right wrong");

	// A logic op aimed at the register moves only the negative and zero flags.
	property p_dest_logic;
		exec_valid && dest_is_flags && (op == asfr_pkg::OP_AND) |=>
			flags[asfr_pkg::BIT_N] == result[7] &&
			flags[asfr_pkg::BIT_Z] == (result == 8'h00) &&
			flags[asfr_pkg::BIT_C] == $past(flags[asfr_pkg::BIT_C]) &&
			{flags[asfr_pkg::BIT_SIGNED_WRAP], flags[asfr_pkg::BIT_NIBBLE_WRAP]} ==
			$past({flags[asfr_pkg::BIT_SIGNED_WRAP], flags[asfr_pkg::BIT_NIBBLE_WRAP]});
	endproperty
	a_dest_logic: assert property (p_dest_logic) else $error("logic write not blocked");

	property p_sub_dest;
		exec_valid && dest_is_flags && (op == asfr_pkg::OP_SUB) |=>
			flags[asfr_pkg::BIT_C] == !$past(chk_sub[8]) &&
			flags[asfr_pkg::BIT_Z] == (result == 8'h00);
	endproperty
	a_sub_dest: assert property (p_sub_dest) else $error("subtract write not blocked");

	property p_acc_move_in;
		exec_valid && dest_is_flags && (op == asfr_pkg::OP_ACCUMULATOR_TO_FILE_MOVE) |=>
			flags == ($past(acc_data) & asfr_pkg::FLAGS_IMPL_MASK);
	endproperty
	a_acc_move_in: assert property (p_acc_move_in) else $error("accumulator move lost");

	property p_idle;
		!exec_valid |=> $stable(flags) && !result_valid;
	endproperty
	a_idle: assert property (p_idle) else $error("state moved without instruction");

	// The datapath may read the result late, so it must not drift while idle.
	property p_result_hold;
		!exec_valid |=> $stable(result);
	endproperty
	a_result_hold: assert property (p_result_hold) else $error("result moved without instruction");

	c_sub_dest:  cover property (exec_valid && dest_is_flags && op == asfr_pkg::OP_SUB);
	c_wipe:      cover property (exec_valid && dest_is_flags && op == asfr_pkg::OP_FILE_WIPE);
	c_ovf:       cover property (exec_valid ##1 flags[asfr_pkg::BIT_SIGNED_WRAP]);
	c_rot_chain: cover property (exec_valid && op == asfr_pkg::OP_ROTATE_RIGHT ##1
				     exec_valid && op == asfr_pkg::OP_ROTATE_RIGHT);

endmodule : asfr_flag_reg

`default_nettype wire

// *** tb/asfr_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// Execution datapath model: presents one instruction per call and scrambles operands when idle.
module asfr_core_model (
	output var logic               exec_valid,
	output var asfr_pkg::asfr_op_t op,
	output var logic [7:0]         src_data,
	output var logic               src_is_flags,
	output var logic [7:0]         acc_data,
	output var logic [2:0]         bit_sel,
	output var logic               dest_is_flags
);
	initial begin
		exec_valid    = 1'b0;
		op            = asfr_pkg::OP_ADD;
		src_data      = 8'h00;
		src_is_flags  = 1'b0;
		acc_data      = 8'h00;
		bit_sel       = 3'h0;
		dest_is_flags = 1'b0;
	end

	task issue(input asfr_pkg::asfr_op_t o, input logic [7:0] s, input logic [7:0] a,
		input logic sf, input logic df, input logic [2:0] b);
		exec_valid    = 1'b1;
		op            = o;
		src_data      = s;
		acc_data      = a;
		src_is_flags  = sf;
		dest_is_flags = df;
		bit_sel       = b;
	endtask : issue

	// Idle operands do not hold their last value, so a design that ignores exec_valid shows it.
	task rest;
		exec_valid    = 1'b0;
		src_data      = ~src_data;
		acc_data      = ~acc_data;
		bit_sel       = ~bit_sel;
		src_is_flags  = ~src_is_flags;
		dest_is_flags = ~dest_is_flags;
	endtask : rest
endmodule : asfr_core_model

`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none

module testbench;
	typedef struct packed {
		asfr_pkg::asfr_op_t op;
		logic [7:0]         s;
		logic [7:0]         a;
		logic               sf;
		logic               df;
		logic [2:0]         b;
		logic [7:0]         r;
		logic [7:0]         f;
	} asfr_step_t;

	logic               clk;
	logic               rst;
	logic               exec_valid;
	asfr_pkg::asfr_op_t op;
	logic [7:0]         src_data;
	logic               src_is_flags;
	logic [7:0]         acc_data;
	logic [2:0]         bit_sel;
	logic               dest_is_flags;
	logic [7:0]         flags;
	logic [7:0]         result;
	logic               result_valid;
	int                 errors;
	int                 check_count;
	asfr_step_t         steps[$];

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	asfr_core_model model (.exec_valid(exec_valid), .op(op), .src_data(src_data),
		.src_is_flags(src_is_flags), .acc_data(acc_data), .bit_sel(bit_sel),
		.dest_is_flags(dest_is_flags));

	asfr_flag_reg uut (.clk(clk), .rst(rst), .exec_valid(exec_valid), .op(op),
		.src_data(src_data), .src_is_flags(src_is_flags), .acc_data(acc_data),
		.bit_sel(bit_sel), .dest_is_flags(dest_is_flags), .flags(flags),
		.result(result), .result_valid(result_valid));

	task check8(input string name, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", name, exp, got);
		end
	endtask : check8

	task add(input asfr_pkg::asfr_op_t o, input logic [7:0] s, input logic [7:0] a,
		input logic sf, input logic df, input logic [2:0] b, input logic [7:0] r,
		input logic [7:0] f);
		steps.push_back('{o, s, a, sf, df, b, r, f});
	endtask : add

	task conclude;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : conclude

	initial begin
		repeat (2000) @(posedge clk);
		errors++;
		conclude();
	end

	initial begin
		errors = 0;
		check_count = 0;
		rst = 1'b1;
		add(asfr_pkg::OP_ADD, 8'h7f, 8'h01, 1'b0, 1'b0, 3'h0, 8'h80, 8'h1a);
		add(asfr_pkg::OP_ADD, 8'hff, 8'h01, 1'b0, 1'b0, 3'h0, 8'h00, 8'h07);
		add(asfr_pkg::OP_SUB, 8'h00, 8'h01, 1'b0, 1'b0, 3'h0, 8'hff, 8'h10);
		add(asfr_pkg::OP_SUB, 8'h80, 8'h01, 1'b0, 1'b0, 3'h0, 8'h7f, 8'h09);
		add(asfr_pkg::OP_ROTATE_LEFT, 8'h88, 8'h00, 1'b0, 1'b0, 3'h0, 8'h11, 8'h0b);
		add(asfr_pkg::OP_ROTATE_RIGHT, 8'h10, 8'h00, 1'b0, 1'b0, 3'h0, 8'h88, 8'h1a);
		add(asfr_pkg::OP_AND, 8'hff, 8'h00, 1'b0, 1'b0, 3'h0, 8'h00, 8'h0e);
		add(asfr_pkg::OP_IOR, 8'h80, 8'h00, 1'b0, 1'b0, 3'h0, 8'h80, 8'h1a);
		add(asfr_pkg::OP_XOR, 8'h55, 8'h55, 1'b0, 1'b0, 3'h0, 8'h00, 8'h0e);
		add(asfr_pkg::OP_INC, 8'hff, 8'h00, 1'b0, 1'b0, 3'h0, 8'h00, 8'h07);
		add(asfr_pkg::OP_DEC, 8'h00, 8'h00, 1'b0, 1'b0, 3'h0, 8'hff, 8'h10);
		add(asfr_pkg::OP_BIT_SET, 8'h00, 8'h00, 1'b0, 1'b0, 3'h3, 8'h08, 8'h10);
		add(asfr_pkg::OP_BIT_CLEAR, 8'hff, 8'h00, 1'b0, 1'b0, 3'h0, 8'hfe, 8'h10);
		add(asfr_pkg::OP_NIBBLE_EXCHANGE, 8'ha5, 8'h00, 1'b0, 1'b0, 3'h0, 8'h5a, 8'h10);
		add(asfr_pkg::OP_FILE_TO_FILE_MOVE, 8'h00, 8'h00, 1'b0, 1'b0, 3'h0, 8'h00, 8'h10);
		add(asfr_pkg::OP_ACCUMULATOR_TO_FILE_MOVE, 8'h33, 8'h3c, 1'b0, 1'b0, 3'h0, 8'h3c, 8'h10);
		add(asfr_pkg::OP_FILE_TO_FILE_MOVE, 8'hfb, 8'h00, 1'b0, 1'b1, 3'h0, 8'hfb, 8'h1b);
		add(asfr_pkg::OP_FILE_WIPE, 8'h44, 8'h00, 1'b0, 1'b1, 3'h0, 8'h00, 8'h1f);
		add(asfr_pkg::OP_BIT_CLEAR, 8'h00, 8'h00, 1'b1, 1'b1, 3'h0, 8'h1e, 8'h1e);
		add(asfr_pkg::OP_ADD, 8'hff, 8'h01, 1'b0, 1'b1, 3'h0, 8'h00, 8'h07);
		add(asfr_pkg::OP_ADD, 8'h00, 8'h02, 1'b1, 1'b0, 3'h0, 8'h09, 8'h00);
		add(asfr_pkg::OP_SUB, 8'h05, 8'h05, 1'b0, 1'b1, 3'h0, 8'h00, 8'h07);
		add(asfr_pkg::OP_AND, 8'hf0, 8'hff, 1'b0, 1'b1, 3'h0, 8'hf0, 8'h13);
		add(asfr_pkg::OP_ACCUMULATOR_TO_FILE_MOVE, 8'h00, 8'he5, 1'b0, 1'b1, 3'h0, 8'he5, 8'h05);
		repeat (20) @(negedge clk);
		rst = 1'b0;
		check8("reset flags", 8'h00, flags);
		check8("reset valid", 8'h00, {7'h00, result_valid});
		// Instructions go back to back, so exec_valid stays high through the whole table.
		foreach (steps[i]) begin
			model.issue(steps[i].op, steps[i].s, steps[i].a, steps[i].sf, steps[i].df, steps[i].b);
			@(negedge clk);
			check8("result", steps[i].r, result);
			check8("flags", steps[i].f, flags);
			check8("valid", 8'h01, {7'h00, result_valid});
		end
		model.rest();
		@(negedge clk);
		check8("idle valid", 8'h00, {7'h00, result_valid});
		check8("idle flags", 8'h05, flags);
		check8("idle result", 8'he5, result);
		rst = 1'b1;
		@(negedge clk);
		check8("rerun flags", 8'h00, flags);
		check8("rerun result", 8'h00, result);
		rst = 1'b0;
		// The carry left by reset feeds the first rotate after release.
		model.issue(asfr_pkg::OP_ROTATE_LEFT, 8'h40, 8'h00, 1'b0, 1'b0, 3'h0);
		@(negedge clk);
		check8("rerun rotate result", 8'h80, result);
		check8("rerun rotate flags", 8'h10, flags);
		conclude();
	end
endmodule : testbench

`default_nettype wire
